// file: core/lecs_pkg.sv
// Constants for the carry-select logic block: register map, fields, resets.
// Assumes a 32-bit AHB-Lite slave port with word-aligned registers.
package lecs_pkg;
    // Block geometry
    localparam int NUM_LE  = 10;
    localparam int SEG_LEN = 5;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_DATA_LO = 8'h04;
    localparam logic [7:0] OFS_DATA_HI = 8'h08;
    localparam logic [7:0] OFS_STAT    = 8'h0C;
    localparam logic [7:0] OFS_CHAIN   = 8'h10;
    localparam logic [7:0] OFS_CFG     = 8'h40;

    // Block control register fields
    localparam int CTL_ADDNSUB = 0;
    localparam int CTL_CLKEN1  = 1;
    localparam int CTL_CLKEN2  = 2;
    localparam int CTL_ACLR1   = 3;
    localparam int CTL_ACLR2   = 4;
    localparam int CTL_ALOAD   = 5;
    localparam int CTL_SCLR    = 6;
    localparam int CTL_SLOAD   = 7;
    localparam int CTL_CIN     = 8;
    localparam int CTL_CIN_EXT = 9;
    localparam int CTL_RST_EN  = 10;
    localparam int CTRL_W      = 11;
    localparam logic [CTRL_W-1:0] CTRL_RST = 11'h006;

    // Per-element configuration fields
    localparam int CFG_MASK    = 0;
    localparam int CFG_ARITH   = 16;
    localparam int CFG_CIN_D3  = 17;
    localparam int CFG_LUTCH   = 18;
    localparam int CFG_REGCH   = 19;
    localparam int CFG_START   = 20;
    localparam int CFG_CLKSEL  = 21;
    localparam int CFG_CLRSEL  = 22;
    localparam int CFG_PRESET  = 23;
    localparam int CFG_W       = 24;
    localparam logic [CFG_W-1:0] CFG_RST = 24'h000000;

    // Status register fields
    localparam int STAT_COMB   = 0;
    localparam int STAT_REG    = 10;
    localparam int STAT_COUT   = 20;
endpackage

// file: core/lecs_le.sv
// One logic element: look-up function, carry-select adder slice, register.
// Assumes block-wide controls arrive already synchronous to hclk.
module lecs_le
    import lecs_pkg::*;
(
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // Configuration
    input  wire logic [15:0] lut_mask,
    input  wire logic        arith_mode,
    input  wire logic        carry_as_d3,
    input  wire logic        use_lut_chain,
    input  wire logic        reg_chain_src,
    input  wire logic        chain_start,
    input  wire logic        preset_mode,
    // Block-wide controls
    input  wire logic        clk_en,
    input  wire logic        chip_clr,
    input  wire logic        aclr,
    input  wire logic        aload,
    input  wire logic        sclr,
    input  wire logic        sload,
    input  wire logic        addnsub,
    // Element inputs
    input  wire logic [3:0]  data_in,
    input  wire logic        zero_chain_carry_in,
    input  wire logic        one_chain_carry_in,
    input  wire logic        lab_carry_in,
    input  wire logic        reg_chain_in,
    input  wire logic        lut_chain_in,
    // Element outputs
    output logic             comb_out,
    output logic             reg_out,
    output logic             zero_chain_carry_out,
    output logic             one_chain_carry_out
);
    logic       first_operand_input;
    logic       second_operand_input;
    logic       fourth_data_input;
    logic       sub_en;
    logic       b_eff;
    logic       cin0;
    logic       cin1;
    logic       sel_carry;
    logic       sum;
    logic       lut_out;
    logic [3:0] lut_idx;
    logic       q_q;

    assign fourth_data_input    = data_in[3];
    assign first_operand_input  = use_lut_chain ? lut_chain_in : data_in[0];
    assign second_operand_input = data_in[1];

    // Up/down from the fourth input; subtract only counts in arith mode
    assign sub_en = arith_mode & (addnsub ^ fourth_data_input);
    assign b_eff  = second_operand_input ^ sub_en;
    assign cin0   = chain_start ? sub_en : zero_chain_carry_in;
    assign cin1   = chain_start ? sub_en : one_chain_carry_in;
    assign sel_carry = lab_carry_in ? cin1 : cin0;
    // Sum for carry 0 is a^b, for carry 1 its inverse
    assign sum = sel_carry ? ~(first_operand_input ^ b_eff)
                           : (first_operand_input ^ b_eff);
    assign lut_idx = {carry_as_d3 ? sel_carry : fourth_data_input,
                      data_in[2], data_in[1], first_operand_input};
    assign lut_out = lut_mask[lut_idx];

    always_comb begin
        zero_chain_carry_out = cin0 ? (first_operand_input | b_eff)
                                    : (first_operand_input & b_eff);
        one_chain_carry_out  = cin1 ? (first_operand_input | b_eff)
                                    : (first_operand_input & b_eff);
        comb_out             = arith_mode ? sum : lut_out;
        reg_out              = q_q;
    end

    // ************************************************************
    // Register: chip reset, clear, load, then clocked functions
    // ************************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q_q <= 1'b0;
        end else if (chip_clr) begin
            q_q <= 1'b0;
        end else if (aclr) begin
            q_q <= 1'b0;
        end else if (aload) begin
            q_q <= preset_mode | fourth_data_input;
        end else if (clk_en) begin
            if (sclr) begin
                q_q <= 1'b0;
            end else if (sload) begin
                q_q <= fourth_data_input;
            end else if (arith_mode) begin
                if (data_in[2]) begin
                    q_q <= sum;
                end
            end else begin
                q_q <= reg_chain_src ? reg_chain_in : lut_out;
            end
        end
    end
endmodule

// file: core/lecs_lab.sv
// Logic block of ten carry-select elements behind an AHB-Lite slave.
// Assumes a single hclk domain; the two pins are resynchronised here.
// Behaviour
// - Each element takes four data, two chain carries, block carry, register chain.
// - Register gets clock, enable, clears, load/preset, sync clear/load while enabled.
// - Add/subtract select only affects elements in arithmetic mode.
// - Normal mode feeds four inputs into any four-input Boolean function.
// - One look-up input selectable as carry or fourth data input.
// - Look-up output passes directly to next element over a chain path.
// - Asynchronous load value comes from the fourth data input.
// - Look-up output and register may serve unrelated functions independently.
// - Arithmetic uses two sum and two carry functions for carry zero/one.
// - Block carry picks a chain; chain level picks the precomputed sum.
// - Each chain carry-in selects that chain's carry-out between precomputed pair.
// - Counter enable and up/down come from local data inputs.
// - Synchronous clear and load act on all block registers together.
// - Add/subtract select drives the carry into a chain's first element only.
// - Both chain carries feed forward into the next element's sum and chain.
// - A carry chain may start at any element position.
// - Block carry values are generated at element five and element ten.
// - Chains continue across blocks; final carry-out is forwarded onto routing.
// - Preset is an asynchronous load of one, no content inversion.
// - Clear beats preset/load when both asserted; register goes to zero.
// - A block has at most two independent clears and one preset.
// - Enabled chip-wide active-low reset clears all registers, overriding everything.
// - Subtract inverts second operand and forces initial chain carry to one.
// - A deasserted clock enable gates the clock so registers hold.
module lecs_lab
    import lecs_pkg::*;
(
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Block chaining and device pins
    input  wire logic        prev_block_carry_in,
    input  wire logic        chip_wide_reset_n,
    output logic             block_carry_out,
    output logic             reg_chain_out
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    logic [CTRL_W-1:0] ctrl_q;
    logic [CFG_W-1:0]  cfg_q [NUM_LE];
    logic [3:0]        data_q [NUM_LE];
    logic              chain_q;
    logic              wr_pend_q;
    logic [31:0]       waddr_q;
    logic [31:0]       hrdata_q;
    logic              hreadyout_q;
    logic              hresp_q;
    logic [31:0]       rd_d;
    logic              cout_q;
    logic              cin_meta_q;
    logic              cin_sync_q;
    logic              rst_meta_q;
    logic              rst_sync_q;
    logic              addr_ph;

    logic [NUM_LE-1:0] comb;
    logic [NUM_LE-1:0] regq;
    logic [NUM_LE-1:0] c0;
    logic [NUM_LE-1:0] c1;
    logic              blk_cin;
    logic              seg_cin;
    logic              cout_sel;
    logic              chip_clr;
    logic              aclr_any;

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cin_meta_q <= 1'b0;
            cin_sync_q <= 1'b0;
        end else begin
            cin_meta_q <= prev_block_carry_in;
            cin_sync_q <= cin_meta_q;
        end
    end

    // Idles high so the chip reset stays released until the pin is seen
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= 1'b1;
        end else begin
            rst_meta_q <= chip_wide_reset_n;
            rst_sync_q <= rst_meta_q;
        end
    end

    assign chip_clr = ctrl_q[CTL_RST_EN] & ~rst_sync_q;

    // ************************************************************
    // AHB-Lite address and data phase
    // ************************************************************
    assign addr_ph = hsel & htrans[1] & hready;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            waddr_q   <= 32'h00000000;
        end else begin
            wr_pend_q <= addr_ph & hwrite;
            if (addr_ph) begin
                waddr_q <= haddr;
            end
        end
    end

    // Zero wait states: every transfer completes in its first data cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout_q <= 1'b0;
            hresp_q     <= 1'b0;
        end else begin
            hreadyout_q <= 1'b1;
            hresp_q     <= 1'b0;
        end
    end

    // Read mux, decoded from the address phase
    always_comb begin
        logic [7:0] cfg_off;
        rd_d    = 32'h00000000;
        cfg_off = haddr[7:0] - OFS_CFG;
        if (haddr[31:8] == 24'h000000) begin
            case (haddr[7:0])
                OFS_CTRL: begin
                    rd_d[CTRL_W-1:0] = ctrl_q;
                end
                OFS_DATA_LO: begin
                    for (int i = 0; i < 8; i++) begin
                        rd_d[4*i +: 4] = data_q[i];
                    end
                end
                OFS_DATA_HI: begin
                    for (int i = 8; i < NUM_LE; i++) begin
                        rd_d[4*(i-8) +: 4] = data_q[i];
                    end
                end
                OFS_STAT: begin
                    rd_d[STAT_COMB +: NUM_LE] = comb;
                    rd_d[STAT_REG +: NUM_LE]  = regq;
                    rd_d[STAT_COUT]           = cout_q;
                end
                OFS_CHAIN: begin
                    rd_d[0] = chain_q;
                end
                default: begin
                    if (haddr[7:0] >= OFS_CFG &&
                        cfg_off < 8'(4 * NUM_LE)) begin
                        rd_d[CFG_W-1:0] = cfg_q[cfg_off[5:2]];
                    end
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_q <= 32'h00000000;
        end else if (addr_ph && !hwrite) begin
            hrdata_q <= rd_d;
        end
    end

    // ************************************************************
    // Register writes in the data phase
    // ************************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q  <= CTRL_RST;
            chain_q <= 1'b0;
        end else if (wr_pend_q && waddr_q[31:8] == 24'h000000) begin
            if (waddr_q[7:0] == OFS_CTRL) begin
                ctrl_q <= hwdata[CTRL_W-1:0];
            end
            if (waddr_q[7:0] == OFS_CHAIN) begin
                chain_q <= hwdata[0];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < NUM_LE; i++) begin
                data_q[i] <= 4'h0;
            end
        end else if (wr_pend_q && waddr_q[31:8] == 24'h000000) begin
            for (int i = 0; i < NUM_LE; i++) begin
                if (i < 8 && waddr_q[7:0] == OFS_DATA_LO) begin
                    data_q[i] <= hwdata[4*i +: 4];
                end
                if (i >= 8 && waddr_q[7:0] == OFS_DATA_HI) begin
                    data_q[i] <= hwdata[4*(i%8) +: 4];
                end
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < NUM_LE; i++) begin
                cfg_q[i] <= CFG_RST;
            end
        end else if (wr_pend_q && waddr_q[31:8] == 24'h000000) begin
            for (int i = 0; i < NUM_LE; i++) begin
                if (waddr_q[7:0] == OFS_CFG + 8'(4 * i)) begin
                    cfg_q[i] <= hwdata[CFG_W-1:0];
                end
            end
        end
    end

    // ************************************************************
    // Carry-select chain and elements
    // ************************************************************
    assign blk_cin  = ctrl_q[CTL_CIN_EXT] ? cin_sync_q
                                          : ctrl_q[CTL_CIN];
    // Only these two selects sit on the long carry path
    assign seg_cin  = blk_cin ? c1[SEG_LEN-1] : c0[SEG_LEN-1];
    assign cout_sel = seg_cin ? c1[NUM_LE-1] : c0[NUM_LE-1];
    assign aclr_any = ctrl_q[CTL_ACLR1] | ctrl_q[CTL_ACLR2];

    for (genvar i = 0; i < NUM_LE; i++) begin : g_le
        logic cin0_w;
        logic cin1_w;
        logic rch_w;
        logic lch_w;
        logic clr_w;
        logic cen_w;

        // Each segment restarts with both assumed carries
        if (i == 0 || i == SEG_LEN) begin : g_seg
            assign cin0_w = 1'b0;
            assign cin1_w = 1'b1;
        end else begin : g_fwd
            assign cin0_w = c0[i-1];
            assign cin1_w = c1[i-1];
        end

        if (i == 0) begin : g_first
            assign rch_w = chain_q;
            assign lch_w = 1'b0;
        end else begin : g_next
            assign rch_w = regq[i-1];
            assign lch_w = comb[i-1];
        end

        assign clr_w = cfg_q[i][CFG_CLRSEL] ? ctrl_q[CTL_ACLR2]
                                            : ctrl_q[CTL_ACLR1];
        assign cen_w = cfg_q[i][CFG_CLKSEL] ? ctrl_q[CTL_CLKEN2]
                                            : ctrl_q[CTL_CLKEN1];

        lecs_le u_le (
            .hclk                 (hclk),
            .hresetn              (hresetn),
            .lut_mask             (cfg_q[i][CFG_MASK +: 16]),
            .arith_mode           (cfg_q[i][CFG_ARITH]),
            .carry_as_d3          (cfg_q[i][CFG_CIN_D3]),
            .use_lut_chain        (cfg_q[i][CFG_LUTCH]),
            .reg_chain_src        (cfg_q[i][CFG_REGCH]),
            .chain_start          (cfg_q[i][CFG_START]),
            .preset_mode          (cfg_q[i][CFG_PRESET]),
            .clk_en               (cen_w),
            .chip_clr             (chip_clr),
            .aclr                 (clr_w),
            .aload                (ctrl_q[CTL_ALOAD]),
            .sclr                 (ctrl_q[CTL_SCLR]),
            .sload                (ctrl_q[CTL_SLOAD]),
            .addnsub              (ctrl_q[CTL_ADDNSUB]),
            .data_in              (data_q[i]),
            .zero_chain_carry_in  (cin0_w),
            .one_chain_carry_in   (cin1_w),
            .lab_carry_in         (i < SEG_LEN ? blk_cin : seg_cin),
            .reg_chain_in         (rch_w),
            .lut_chain_in         (lch_w),
            .comb_out             (comb[i]),
            .reg_out              (regq[i]),
            .zero_chain_carry_out (c0[i]),
            .one_chain_carry_out  (c1[i])
        );
    end

    // Final carry goes out registered to keep the port glitch-free
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cout_q <= 1'b0;
        end else begin
            cout_q <= cout_sel;
        end
    end

    assign hrdata          = hrdata_q;
    assign hreadyout       = hreadyout_q;
    assign hresp           = hresp_q;
    assign block_carry_out = cout_q;
    assign reg_chain_out   = regq[NUM_LE-1];

    // ************************************************************
    // Checks
    // ************************************************************
    sclr_all_a: assert property (
        ctrl_q[CTL_SCLR] && ctrl_q[CTL_CLKEN1] && ctrl_q[CTL_CLKEN2] &&
        !aclr_any && !ctrl_q[CTL_ALOAD] && !chip_clr
        |=> regq == '0)
        else $error("sync clear left a register set");

    clr_wins_a: assert property (
        ctrl_q[CTL_ACLR1] && ctrl_q[CTL_ACLR2] && ctrl_q[CTL_ALOAD]
        |=> regq == '0)
        else $error("load beat clear");

    preset_one_a: assert property (
        ctrl_q[CTL_ALOAD] && cfg_q[0][CFG_PRESET] && !aclr_any &&
        !chip_clr |=> regq[0])
        else $error("preset did not load one");

    chip_clr_a: assert property (
        chip_clr |=> regq == '0)
        else $error("chip reset did not clear all");

    gated_hold_a: assert property (
        !ctrl_q[CTL_CLKEN1] && !ctrl_q[CTL_CLKEN2] && !aclr_any &&
        !ctrl_q[CTL_ALOAD] && !chip_clr |=> $stable(regq))
        else $error("register moved with clock gated");

    sub_lsb_a: assert property (
        cfg_q[0][CFG_ARITH] && cfg_q[0][CFG_START] &&
        ctrl_q[CTL_ADDNSUB] && data_q[0] == 4'h4
        |-> !comb[0] && c0[0] && c1[0])
        else $error("subtract carry-in not forced");

    carry_out_a: assert property (
        ##1 cout_q == $past(cout_sel))
        else $error("block carry out lagging");

    stat_read_a: assert property (
        addr_ph && !hwrite && haddr == 32'(OFS_STAT)
        |=> hrdata_q[STAT_REG +: NUM_LE] == $past(regq) &&
            hrdata_q[STAT_COMB +: NUM_LE] == $past(comb))
        else $error("status read mismatch");

    ctrl_write_a: assert property (
        wr_pend_q && waddr_q == 32'(OFS_CTRL)
        |=> ctrl_q == $past(hwdata[CTRL_W-1:0]))
        else $error("control write lost");

    add_cov: cover property (
        cfg_q[0][CFG_ARITH] && !ctrl_q[CTL_ADDNSUB] && cout_sel);
    preset_cov: cover property (
        ctrl_q[CTL_ALOAD] && cfg_q[0][CFG_PRESET] ##1 regq[0]);
    sclr_cov: cover property (
        regq != '0 && ctrl_q[CTL_SCLR] ##1 regq == '0);
endmodule

// file: bench/lecs_far_model.sv
// Far side of the logic block: chip reset pin and previous block carry.
// Assumes the bench commands both levels; they change after a clock edge.
module lecs_far_model (
    // Clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    // Bench commands
    input  wire logic rst_req,
    input  wire logic carry_req,
    // Pins toward the block
    output logic      chip_wide_reset_n,
    output logic      prev_block_carry_in
);
    timeunit 1ns;
    timeprecision 1ps;

    // Launched from a flop, as a neighbouring block would
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            chip_wide_reset_n   <= 1'b1;
            prev_block_carry_in <= 1'b0;
        end else begin
            chip_wide_reset_n   <= !rst_req;
            prev_block_carry_in <= carry_req;
        end
    end
endmodule

// file: bench/tb.sv
// Self-checking bench for the carry-select logic block.
// Assumes lecs_far_model drives the chip reset and carry pins.
module tb
    import lecs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        hclk, hresetn, hwrite, hready, hresp, bco, rco;
    logic        rst_req, carry_req, pin_rst_n, pin_cin;
    logic [1:0]  htrans;
    logic [31:0] haddr, hwdata, hrdata, rd;
    int          fail_count, comparisons, cycles;

    always #5 hclk = ~hclk;

    lecs_far_model far_u (.hclk(hclk), .hresetn(hresetn), .rst_req(rst_req),
        .carry_req(carry_req), .chip_wide_reset_n(pin_rst_n),
        .prev_block_carry_in(pin_cin));

    lecs_lab dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hready), .hresp(hresp), .prev_block_carry_in(pin_cin),
        .chip_wide_reset_n(pin_rst_n), .block_carry_out(bco),
        .reg_chain_out(rco));

    // Single transfer; read data taken at the edge ending the data phase
    task automatic bus(input logic w, input logic [31:0] a, d);
        @(posedge hclk);
        haddr  <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask

    task automatic chk(input string n, input logic [31:0] e, g);
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", n, e, g);
        end
    endtask

    task automatic ctl_stat(input logic [31:0] c, input int n);
        bus(1'b1, {24'h0, OFS_CTRL}, c);
        repeat (n) @(posedge hclk);
        bus(1'b0, {24'h0, OFS_STAT}, 32'h0);
    endtask

    task automatic cfg_all(input logic [31:0] even, odd);
        for (int i = 0; i < 10; i++) begin
            bus(1'b1, 32'h40 + 4 * i, (i % 2 == 0) ? even : odd);
        end
    endtask

    task automatic reg_case();
        bus(1'b0, {24'h0, OFS_CTRL}, 32'h0);
        chk("control reset value", 32'h006, rd);
        bus(1'b1, 32'h24, 32'hFFFF);
        bus(1'b0, 32'h24, 32'h0);
        chk("unmapped read", 32'h0, rd);
        chk("response", 32'h0, {31'h0, hresp});
        $display("test registers done");
    endtask

    // Counter enable set, up direction: a plain adder or subtractor
    task automatic add_case(input logic [9:0] a, b, input logic sub, cin);
        logic [10:0] s;
        logic [39:0] p;
        s = {1'b0, a} + {1'b0, b ^ {10{sub}}} + 11'(sub) + 11'(cin);
        for (int i = 0; i < 10; i++) p[4*i+:4] = {2'h1, b[i], a[i]};
        carry_req <= cin;
        bus(1'b1, 32'h40, cin ? 32'h10000 : 32'h110000);
        for (int i = 1; i < 10; i++) bus(1'b1, 32'h40 + 4 * i, 32'h10000);
        bus(1'b1, {24'h0, OFS_DATA_LO}, p[31:0]);
        bus(1'b1, {24'h0, OFS_DATA_HI}, {24'h0, p[39:32]});
        ctl_stat({22'h0, cin, 9'h006} | {31'h0, sub}, 6);
        chk("adder status", {11'h0, s[10], s[9:0], s[9:0]}, rd);
        chk("block carry", {31'h0, s[10]}, {31'h0, bco});
        $display("test adder %h %h done", a, b);
    endtask

    // Every element reads its own index through the same table
    task automatic lut_case();
        cfg_all(32'hE8A5, 32'hE8A5);
        bus(1'b1, {24'h0, OFS_DATA_LO}, 32'h76543210);
        bus(1'b1, {24'h0, OFS_DATA_HI}, 32'h98);
        ctl_stat(32'h006, 2);
        chk("lookup", {12'h0, 10'h0A5, 10'h0A5}, rd & 32'hFFFFF);
        // Gate first, or the registers load the new data on the way
        bus(1'b1, {24'h0, OFS_CTRL}, 32'h0);
        bus(1'b1, {24'h0, OFS_DATA_LO}, 32'h0);
        bus(1'b1, {24'h0, OFS_DATA_HI}, 32'h0);
        ctl_stat(32'h000, 2);
        chk("gated hold", {12'h0, 10'h0A5, 10'h3FF}, rd & 32'hFFFFF);
        ctl_stat(32'h046, 2);
        chk("sync clear", {12'h0, 10'h000, 10'h3FF}, rd & 32'hFFFFF);
        $display("test lookup done");
    endtask

    // Even elements preset, element 1 loads its fourth input
    task automatic async_case();
        cfg_all(32'h80E8A5, 32'hE8A5);
        bus(1'b1, {24'h0, OFS_DATA_LO}, 32'h80);
        ctl_stat(32'h026, 2);
        chk("preset and load", 32'h157, {22'h0, rd[19:10]});
        ctl_stat(32'h03E, 2);
        chk("clear over load", 32'h0, {22'h0, rd[19:10]});
        rst_req <= 1'b1;
        ctl_stat(32'h426, 6);
        chk("chip reset", 32'h0, {22'h0, rd[19:10]});
        rst_req <= 1'b0;
        ctl_stat(32'h426, 6);
        chk("after chip reset", 32'h157, {22'h0, rd[19:10]});
        $display("test asynchronous controls done");
    endtask

    // Registers shift from the chain input; look-up chain alternates
    task automatic chain_case();
        bus(1'b1, {24'h0, OFS_CHAIN}, 32'h1);
        cfg_all(32'hC5555, 32'hC5555);
        ctl_stat(32'h006, 12);
        chk("chains", {12'h0, 10'h3FF, 10'h155}, rd & 32'hFFFFF);
        chk("register chain out", 32'h1, {31'h0, rco});
        $display("test chains done");
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // A hung handshake would otherwise stall the run forever
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            report_and_stop();
        end
    end

    initial begin
        hclk = 1'b0;
        hresetn = 1'b0;
        htrans = 2'h0;
        haddr = 32'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        rst_req = 1'b0;
        carry_req = 1'b0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        reg_case();
        add_case(10'h3FF, 10'h001, 1'b0, 1'b0);
        add_case(10'h155, 10'h2AA, 1'b0, 1'b1);
        add_case(10'h200, 10'h002, 1'b1, 1'b0);
        add_case(10'h001, 10'h002, 1'b1, 1'b0);
        lut_case();
        async_case();
        chain_case();
        report_and_stop();
    end
endmodule
